// ### mph_pkg.sv
package mph_pkg;
  localparam int MPH_DATA_W   = 8;
  localparam int MPH_ADDR_W   = 8;
  localparam int MPH_LOW_W    = 7;
  localparam int MPH_NUM_XCVR = 4;
  localparam int MPH_REGS     = 256;
  localparam logic [7:0] MPH_CFG_RESET = 8'h00;
  localparam logic [7:0] MPH_ZERO_BYTE = 8'h00;
  localparam logic [6:0] MPH_LOW_IDLE  = 7'h00;
  localparam logic [3:0] MPH_SEL_IDLE  = 4'hf;
  // Offset of the per-transceiver status byte whose nonzero value raises the interrupt
  localparam logic [7:0] MPH_STATUS_OFS = 8'hff;
  // Last host sequencer hold phase per access
  localparam logic [2:0] MPH_PHASE_LAST = 3'h3;

  typedef enum logic [2:0] {
    MPH_IDLE   = 3'b000,
    MPH_ADDR   = 3'b001,
    MPH_LATCH  = 3'b010,
    MPH_STROBE = 3'b011,
    MPH_HOLD   = 3'b100,
    MPH_DONE   = 3'b101
  } mph_state_e;
endpackage

// ### mph_bus_if.sv
`timescale 1ns/100ps
interface mph_bus_if;
  import mph_pkg::*;
  logic [7:0] host_ad_out;
  logic       host_ad_oe;
  logic [7:0] dev_ad_out;
  logic       dev_ad_oe;
  logic [7:0] shared_data_addr_bus;
  logic [6:0] low_address_bus;
  logic       upper_addr_or_latch;
  logic       read_or_data_strobe_n;
  logic       write_or_dir_n;
  logic [3:0] xcvr_select_n;
  logic       bus_style_select;
  logic       bus_mux_select;
  logic       test_float_reset;
  logic       int_n_oe;
  logic       int_n;

  // Wire resolution of the shared bus; device and host never both drive
  assign shared_data_addr_bus = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : 8'h00);
  // Open-drain interrupt, pulled up when undriven
  assign int_n = ~int_n_oe;

  modport device (
    input  shared_data_addr_bus, low_address_bus, upper_addr_or_latch, read_or_data_strobe_n,
    input  write_or_dir_n, xcvr_select_n, bus_style_select, bus_mux_select, test_float_reset,
    output dev_ad_out, dev_ad_oe, int_n_oe
  );
  modport host (
    input  shared_data_addr_bus, int_n,
    output host_ad_out, host_ad_oe, low_address_bus, upper_addr_or_latch,
    output read_or_data_strobe_n, write_or_dir_n, xcvr_select_n, bus_style_select,
    output bus_mux_select, test_float_reset
  );
endinterface

// ### mph_device_port.sv
`timescale 1ns/100ps
// Functional notes
// - Open-drain low interrupt while status pending
// - Rising float/reset input zeroes all registers
// - Float/reset high tristates every output
// - Mux strap low separate, high shared
// - Shared pins carry data, or address too
// - Low address used only when separate
// - Upper bit or rising-edge address latch
// - Style strap picks strobe or read/write timing
// - Style high: data strobe, direction, address strobe
// - Read strobe low; data strobe high unmultiplexed
// - Each transceiver has low-active select
// - Write takes effect once, on the first clock of an active strobe
module mph_device_port
  import mph_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  mph_bus_if.device                 bus,
  input  wire logic [MPH_NUM_XCVR-1:0] status_pending,
  output logic [MPH_NUM_XCVR-1:0]   reg_write_pulse,
  output logic [MPH_ADDR_W-1:0]     reg_addr
);
  logic [MPH_DATA_W-1:0] regs_q [MPH_NUM_XCVR][MPH_REGS];
  logic [MPH_ADDR_W-1:0] latched_addr_q;
  logic                  ale_prev_q;
  logic                  tst_prev_q;
  logic                  wr_prev_q;
  logic [MPH_DATA_W-1:0] dout_q;
  logic                  doe_q;
  logic                  int_oe_q;
  logic [MPH_NUM_XCVR-1:0] wpulse_q;
  logic [MPH_ADDR_W-1:0] addr_q;
  logic                  muxed;
  logic                  style_hi;
  logic [MPH_ADDR_W-1:0] cur_addr;
  logic                  rd_act;
  logic                  wr_act;
  logic [MPH_NUM_XCVR-1:0] sel;
  logic                  any_sel;
  logic [1:0]            sel_idx;
  logic                  floated;
  logic                  ds_act;
  logic                  ale_rise;
  logic                  clr_start;
  logic                  wr_start;
  logic [MPH_NUM_XCVR-1:0] first_sel;
  logic [MPH_NUM_XCVR-1:0] bank_wr;
  logic [MPH_NUM_XCVR-1:0] bank_irq;
  logic [MPH_DATA_W-1:0] bank_rd [MPH_NUM_XCVR];

  always_comb begin
    muxed    = bus.bus_mux_select;
    style_hi = bus.bus_style_select;
    floated  = bus.test_float_reset;
  end

  // Lowest selected transceiver wins if several are low
  always_comb begin
    sel       = ~bus.xcvr_select_n;
    any_sel   = |sel;
    sel_idx   = 2'd0;
    first_sel = '0;
    for (int i = MPH_NUM_XCVR - 1; i >= 0; i--) begin
      if (sel[i]) begin
        sel_idx = 2'(i);
      end
    end
    first_sel[sel_idx] = any_sel;
  end

  always_comb begin
    cur_addr = muxed ? latched_addr_q : {bus.upper_addr_or_latch, bus.low_address_bus};
    ale_rise = muxed & bus.upper_addr_or_latch & ~ale_prev_q;
  end

  always_comb begin
    ds_act = muxed ? ~bus.read_or_data_strobe_n : bus.read_or_data_strobe_n;
    if (style_hi) begin
      rd_act = ds_act & bus.write_or_dir_n;
      wr_act = ds_act & ~bus.write_or_dir_n;
    end else begin
      rd_act = ~bus.read_or_data_strobe_n;
      wr_act = ~bus.write_or_dir_n;
    end
  end

  always_comb begin
    clr_start = floated & ~tst_prev_q;
    wr_start  = ~floated & wr_act & any_sel & ~wr_prev_q;
  end

  // address capture on rising latch edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ale_prev_q     <= 1'b0;
      latched_addr_q <= MPH_ZERO_BYTE;
    end else begin
      ale_prev_q <= bus.upper_addr_or_latch;
      // shared pins carry address when muxed
      if (ale_rise) begin
        latched_addr_q <= bus.shared_data_addr_bus;
      end
    end
  end

  // Edge history; a held strobe or float level acts once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tst_prev_q <= 1'b0;
      wr_prev_q  <= 1'b0;
    end else begin
      tst_prev_q <= floated;
      wr_prev_q  <= wr_act & any_sel;
    end
  end

  for (genvar t = 0; t < MPH_NUM_XCVR; t++) begin : g_bank
    assign bank_wr[t] = wr_start & first_sel[t];
    assign bank_rd[t] = regs_q[t][cur_addr];
    assign bank_irq[t] = status_pending[t] | (regs_q[t][MPH_STATUS_OFS] != MPH_ZERO_BYTE);

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        for (int r = 0; r < MPH_REGS; r++) begin
          regs_q[t][r] <= MPH_CFG_RESET;
        end
      end else if (clr_start) begin
        for (int r = 0; r < MPH_REGS; r++) begin
          regs_q[t][r] <= MPH_CFG_RESET;
        end
      end else if (bank_wr[t]) begin
        regs_q[t][cur_addr] <= bus.shared_data_addr_bus;
      end
    end
  end

  // Pulse follows the bank actually written
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wpulse_q <= '0;
    end else begin
      wpulse_q <= bank_wr;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= MPH_ZERO_BYTE;
    end else if (wr_start) begin
      addr_q <= cur_addr;
    end
  end

  // Read data one cycle behind the address
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= MPH_ZERO_BYTE;
    end else begin
      dout_q <= bank_rd[sel_idx];
    end
  end

  // Drive enable, registered so the pin never glitches
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      doe_q <= 1'b0;
    end else begin
      doe_q <= any_sel & rd_act & ~floated;
    end
  end

  // Interrupt from status bytes or external pending
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_oe_q <= 1'b0;
    end else begin
      // pull low while any status pending
      int_oe_q <= (|bank_irq) & ~floated;
    end
  end

  assign bus.dev_ad_out   = dout_q;
  assign bus.dev_ad_oe    = doe_q;
  assign bus.int_n_oe     = int_oe_q;
  assign reg_write_pulse  = wpulse_q;
  assign reg_addr         = addr_q;
endmodule

// ### mph_host_port.sv
`timescale 1ns/100ps
module mph_host_port
  import mph_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  mph_bus_if.host                   bus,
  input  wire logic                 cfg_muxed,
  input  wire logic                 cfg_style,
  input  wire logic                 float_req,
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic [1:0]           req_xcvr,
  input  wire logic [MPH_ADDR_W-1:0] req_addr,
  input  wire logic [MPH_DATA_W-1:0] req_wdata,
  output logic                      req_ready,
  output logic                      rsp_valid,
  output logic [MPH_DATA_W-1:0]     rsp_rdata,
  output logic                      irq_seen
);
  mph_state_e            state_q;
  logic [2:0]            phase_q;
  logic                  wr_q;
  logic [1:0]            xcvr_q;
  logic [MPH_ADDR_W-1:0] addr_q;
  logic [MPH_DATA_W-1:0] wdata_q;
  logic [MPH_DATA_W-1:0] rdata_q;
  logic                  rsp_q;
  logic                  irq_q;
  logic                  ready_q;
  logic [MPH_DATA_W-1:0] ad_out_q;
  logic                  ad_oe_q;
  logic [6:0]            low_q;
  logic                  ale_q;
  logic                  rd_n_q;
  logic                  wr_n_q;
  logic [3:0]            sel_n_q;
  logic                  active;
  logic                  strobe_on;

  always_comb begin
    active    = (state_q == MPH_STROBE) || (state_q == MPH_HOLD);
    strobe_on = (cfg_style && !cfg_muxed) ? 1'b1 : 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= MPH_IDLE;
      phase_q <= 3'h0;
      wr_q    <= 1'b0;
      xcvr_q  <= 2'd0;
      addr_q  <= MPH_ZERO_BYTE;
      wdata_q <= MPH_ZERO_BYTE;
      rdata_q <= MPH_ZERO_BYTE;
      rsp_q   <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rsp_q   <= 1'b0;
      ready_q <= (state_q == MPH_IDLE) && !float_req;
      case (state_q)
        MPH_IDLE: begin
          if (req_valid && ready_q) begin
            wr_q    <= req_write;
            xcvr_q  <= req_xcvr;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            ready_q <= 1'b0;
            state_q <= cfg_muxed ? MPH_ADDR : MPH_STROBE;
          end
        end
        MPH_ADDR:   state_q <= MPH_LATCH;
        MPH_LATCH:  state_q <= MPH_STROBE;
        MPH_STROBE: begin
          phase_q <= 3'h0;
          state_q <= MPH_HOLD;
        end
        MPH_HOLD: begin
          phase_q <= phase_q + 3'h1;
          if (phase_q == MPH_PHASE_LAST) begin
            rdata_q <= bus.shared_data_addr_bus;
            state_q <= MPH_DONE;
          end
        end
        MPH_DONE: begin
          rsp_q   <= 1'b1;
          state_q <= MPH_IDLE;
        end
        default: state_q <= MPH_IDLE;
      endcase
    end
  end

  // Pin drive
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ad_out_q <= MPH_ZERO_BYTE;
      ad_oe_q  <= 1'b0;
      low_q    <= MPH_LOW_IDLE;
      ale_q    <= 1'b0;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
      sel_n_q  <= MPH_SEL_IDLE;
      irq_q    <= 1'b0;
    end else begin
      irq_q   <= ~bus.int_n;
      // hold low address low when muxed
      low_q   <= cfg_muxed ? MPH_LOW_IDLE : addr_q[6:0];
      // latch pulse rises with the address on the shared pins
      ale_q   <= cfg_muxed ? (state_q == MPH_ADDR) : addr_q[7];
      ad_out_q <= (cfg_muxed && state_q == MPH_ADDR) ? addr_q : wdata_q;
      ad_oe_q  <= (cfg_muxed && (state_q == MPH_ADDR || state_q == MPH_LATCH))
                  || (active && wr_q);
      sel_n_q  <= active ? ~(4'h1 << xcvr_q) : MPH_SEL_IDLE;
      // data strobe and direction in style high
      if (cfg_style) begin
        rd_n_q <= active ? strobe_on : ~strobe_on;
        wr_n_q <= ~wr_q;
      end else begin
        rd_n_q <= ~(active && !wr_q);
        wr_n_q <= ~(active && wr_q);
      end
    end
  end

  assign bus.host_ad_out           = ad_out_q;
  assign bus.host_ad_oe            = ad_oe_q;
  assign bus.low_address_bus       = low_q;
  assign bus.upper_addr_or_latch   = ale_q;
  assign bus.read_or_data_strobe_n = rd_n_q;
  assign bus.write_or_dir_n        = wr_n_q;
  assign bus.xcvr_select_n         = sel_n_q;
  assign bus.bus_style_select      = cfg_style;
  assign bus.bus_mux_select        = cfg_muxed;
  assign bus.test_float_reset      = float_req;
  assign req_ready                 = ready_q;
  assign rsp_valid                 = rsp_q;
  assign rsp_rdata                 = rdata_q;
  assign irq_seen                  = irq_q;
endmodule

// ### mph_bus_chk.sv
`timescale 1ns/100ps
module mph_bus_chk
  import mph_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       host_ad_oe,
  input wire logic       dev_ad_oe,
  input wire logic [6:0] low_address_bus,
  input wire logic       upper_addr_or_latch,
  input wire logic       read_or_data_strobe_n,
  input wire logic       write_or_dir_n,
  input wire logic [3:0] xcvr_select_n,
  input wire logic       bus_style_select,
  input wire logic       bus_mux_select,
  input wire logic       test_float_reset,
  input wire logic       int_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic sel_any;
  logic ds_act;
  logic rd_act;
  logic rd_sel;
  assign sel_any = (xcvr_select_n != MPH_SEL_IDLE);
  // Data strobe flips polarity with the mux strap
  assign ds_act = bus_mux_select ? !read_or_data_strobe_n : read_or_data_strobe_n;
  assign rd_act = bus_style_select ? (write_or_dir_n && ds_act) : !read_or_data_strobe_n;
  assign rd_sel = sel_any && rd_act;

  sequence rd_held;
    (rd_sel && !test_float_reset) [*2];
  endsequence

  float_quiet_a : assert property (
    test_float_reset |=> !dev_ad_oe && !int_n_oe) else $error("outputs driven while floated");
  drive_cause_a : assert property (
    dev_ad_oe |-> $past(rd_sel)) else $error("bus driven without select and read");
  read_answer_a : assert property (
    rd_held |-> dev_ad_oe) else $error("selected read not answered");
  no_contend_a : assert property (
    !(dev_ad_oe && host_ad_oe)) else $error("both ends drive the shared bus");
  mux_low_a : assert property (
    bus_mux_select && sel_any |-> low_address_bus == MPH_LOW_IDLE) else $error("low address not low");
  write_sel_a : assert property (
    !bus_style_select && !write_or_dir_n |-> sel_any) else $error("write strobe without select");
  one_select_a : assert property (
    $onehot0(~xcvr_select_n)) else $error("several transceivers selected");
  latch_addr_a : assert property (
    $rose(upper_addr_or_latch) && bus_mux_select |-> host_ad_oe) else $error("latch without address");
endmodule

// ### test_mux_parallel_host_port.sv
`timescale 1ns/100ps
module test_mux_parallel_host_port;
  import mph_pkg::*;
  typedef struct packed {
    logic       muxed;
    logic       style;
    logic [1:0] xcvr;
    logic [7:0] addr;
    logic [7:0] data;
  } mph_row_s;
  logic       mclk, rst_b, cfg_muxed, cfg_style, float_req, req_valid, req_write;
  logic [1:0] req_xcvr;
  logic [7:0] req_addr, req_wdata, rsp_rdata, reg_addr;
  logic       req_ready, rsp_valid, irq_seen;
  logic [3:0] status_pending, reg_write_pulse, wp_q;
  logic       wp_clr;
  int         fails, n_checks;
  mph_row_s   rows [8] = '{
    '{1'h0, 1'h0, 2'h0, 8'h00, 8'ha5}, '{1'h0, 1'h0, 2'h1, 8'h80, 8'h5a},
    '{1'h0, 1'h1, 2'h2, 8'h7f, 8'h01}, '{1'h0, 1'h1, 2'h3, 8'h81, 8'hfe},
    '{1'h1, 1'h0, 2'h0, 8'h3c, 8'h80}, '{1'h1, 1'h0, 2'h1, 8'hc3, 8'h7f},
    '{1'h1, 1'h1, 2'h2, 8'h55, 8'hff}, '{1'h1, 1'h1, 2'h3, 8'haa, 8'h96}};

  mph_bus_if mph_bus_if_i ();
  mph_device_port mph_device_port_i (.mclk(mclk), .rst_b(rst_b), .bus(mph_bus_if_i),
    .status_pending(status_pending), .reg_write_pulse(reg_write_pulse), .reg_addr(reg_addr));
  mph_host_port mph_host_port_i (.mclk(mclk), .rst_b(rst_b), .bus(mph_bus_if_i),
    .cfg_muxed(cfg_muxed), .cfg_style(cfg_style), .float_req(float_req),
    .req_valid(req_valid), .req_write(req_write), .req_xcvr(req_xcvr), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
  mph_bus_chk mph_bus_chk_i (.mclk(mclk), .rst_b(rst_b),
    .host_ad_oe(mph_bus_if_i.host_ad_oe), .dev_ad_oe(mph_bus_if_i.dev_ad_oe),
    .low_address_bus(mph_bus_if_i.low_address_bus),
    .upper_addr_or_latch(mph_bus_if_i.upper_addr_or_latch),
    .read_or_data_strobe_n(mph_bus_if_i.read_or_data_strobe_n),
    .write_or_dir_n(mph_bus_if_i.write_or_dir_n), .xcvr_select_n(mph_bus_if_i.xcvr_select_n),
    .bus_style_select(mph_bus_if_i.bus_style_select),
    .bus_mux_select(mph_bus_if_i.bus_mux_select),
    .test_float_reset(mph_bus_if_i.test_float_reset), .int_n_oe(mph_bus_if_i.int_n_oe));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Pulses last one cycle, so keep them until looked at
  always @(posedge mclk) begin
    if (wp_clr) wp_q <= 4'h0;
    else if (|reg_write_pulse) wp_q <= wp_q | reg_write_pulse;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [1:0] x, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    wp_clr = 1'b1;
    @(negedge mclk);
    wp_clr = 1'b0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_xcvr = x;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 30) begin
      fails++;
      $display("Error %0t: no response", $time);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(5000 * 5);
    fails++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    {rst_b, cfg_muxed, cfg_style, float_req, req_valid, req_write} = 6'h00;
    {req_xcvr, req_addr, req_wdata, status_pending} = 22'h0;
    wp_clr = 1'b1;
    fails = 0;
    n_checks = 0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    chk({7'h0, irq_seen}, 8'h00);
    foreach (rows[i]) begin
      cfg_muxed = rows[i].muxed;
      cfg_style = rows[i].style;
      xfer(1'b1, rows[i].xcvr, rows[i].addr, rows[i].data);
      chk({4'h0, wp_q}, 8'h01 << rows[i].xcvr);
      chk(reg_addr, rows[i].addr);
      xfer(1'b0, rows[i].xcvr, rows[i].addr, 8'h00);
      chk(rsp_rdata, rows[i].data);
      chk({4'h0, wp_q}, 8'h00);
    end
    // Same address, other transceiver stays untouched
    xfer(1'b0, 2'h1, 8'h00, 8'h00);
    chk(rsp_rdata, 8'h00);
    // Status byte of one transceiver raises the interrupt
    xfer(1'b1, 2'h2, MPH_STATUS_OFS, 8'h10);
    repeat (3) @(negedge mclk);
    chk({7'h0, irq_seen}, 8'h01);
    xfer(1'b1, 2'h2, MPH_STATUS_OFS, 8'h00);
    repeat (3) @(negedge mclk);
    chk({7'h0, irq_seen}, 8'h00);
    status_pending = 4'h4;
    repeat (4) @(negedge mclk);
    chk({6'h0, irq_seen, mph_bus_if_i.int_n}, 8'h02);
    status_pending = 4'h0;
    repeat (4) @(negedge mclk);
    chk({6'h0, irq_seen, mph_bus_if_i.int_n}, 8'h01);
    float_req = 1'b1;
    status_pending = 4'h1;
    repeat (4) @(negedge mclk);
    chk({5'h0, mph_bus_if_i.dev_ad_oe, mph_bus_if_i.int_n_oe, req_ready}, 8'h00);
    float_req = 1'b0;
    status_pending = 4'h0;
    repeat (4) @(negedge mclk);
    xfer(1'b0, rows[7].xcvr, rows[7].addr, 8'h00);
    chk(rsp_rdata, 8'h00);
    stop_test();
  end
endmodule
